// >>> pkg/flr_pkg.sv
// package for the fault log and converter result register bank
package flr_pkg;
  // ---------------------------------------------
  // register map, low three address bits only
  // ---------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] FAULT_LOG_ADDR = 3'h3;
  localparam logic [2:0] SHUNT_RESULT_ADDR = 3'h4;
  localparam logic [2:0] OUTPUT_RESULT_ADDR = 3'h5;
  localparam logic [2:0] SPARE_RESULT_ADDR = 3'h6;
  // ---------------------------------------------
  // fault log field positions
  // ---------------------------------------------
  localparam int FLT_OV_BIT = 0;
  localparam int FLT_UV_BIT = 1;
  localparam int FLT_OC_BIT = 2;
  localparam int FLT_PBAD_BIT = 3;
  localparam int FLT_CARD_BIT = 4;
  localparam int FLT_SHORT_BIT = 5;
  localparam logic [7:0] FAULT_LOG_MASK = 8'h3f;
  // ---------------------------------------------
  // reset values and thresholds
  // ---------------------------------------------
  localparam logic [7:0] FAULT_LOG_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  // short suspected from code 7 up, the first code above 2 mV at 300 uV per lsb
  localparam logic [7:0] SHORT_THRESHOLD_CODE = 8'h07;
  // pin edges are ignored until the sync pipe has filled after reset
  localparam int PIN_SETTLE_CYCLES = 6;
  // scale figures, for reference by software models
  localparam int SHUNT_LSB_NV = 300000;
  localparam int OUTPUT_LSB_UV = 400000;
  localparam int SPARE_LSB_UV = 10000;
endpackage : flr_pkg

// >>> src/flr_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module flr_sync
  import flr_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge mclk)
      begin
        if (rst)
        begin
          s1_reg[i] <= 1'b0;
          s2_reg[i] <= 1'b0;
          s3_reg[i] <= 1'b0;
          level[i] <= 1'b0;
        end
        else
        begin
          s1_reg[i] <= pin[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          // a change counts only once stages two and three agree
          if (s2_reg[i] == s3_reg[i])
            level[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule : flr_sync

// >>> src/flr_regs.sv
// fault log and converter result register bank
//
// Function
// - set bit 5 when shunt code reaches 7 while the transistor is commanded off
// - set bit 4 on any change of the card presence pin
// - set bit 3 when feedback falls low while gate drive is high
// - set bit 2 when an overcurrent fault occurs; held until written zero
// - set bit 1 when the low-limit comparator input goes low
// - set bit 0 when the high-limit comparator input goes high
// - fault log at address 3, read and write, bits 7 and 6 reserved
// - shunt voltage result at address 4, 300 uV per lsb
// - output voltage result at address 5, 400 mV per lsb
// - spare input result at address 6, 10 mV per lsb
// - address 4 is also answered at every address whose low three bits are 4
// - result registers take host writes only while test mode is set
// - only the low three address bits are decoded
`timescale 1ns/10ps
module flr_regs
  import flr_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic test_mode_bit,
  input wire logic fet_on_cmd,
  input wire logic overcurrent_event,
  input wire logic gate_drive_high,
  input wire logic card_presence_pin,
  input wire logic power_good_feedback,
  input wire logic low_limit_comparator_input,
  input wire logic high_limit_comparator_input,
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] shunt_sample,
  input wire logic [DATA_W-1:0] output_sample,
  input wire logic [DATA_W-1:0] spare_sample,
  output logic [DATA_W-1:0] fault_log,
  output logic [DATA_W-1:0] shunt_voltage_result,
  output logic [DATA_W-1:0] output_voltage_result,
  output logic [DATA_W-1:0] spare_input_result
);
  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  logic [3:0] pins_sync;
  logic [3:0] pins_prev_reg;
  logic prev_valid_reg;
  logic [2:0] settle_cnt_reg;
  logic [2:0] settle_cnt_next;

  flr_sync #(.WIDTH(4)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin({card_presence_pin, power_good_feedback, low_limit_comparator_input, high_limit_comparator_input}),
    .level(pins_sync)
  );

  wire card_now = pins_sync[3];
  wire fb_now = pins_sync[2];
  wire uv_now = pins_sync[1];
  wire ov_now = pins_sync[0];
  wire card_prev = pins_prev_reg[3];
  wire fb_prev = pins_prev_reg[2];
  wire uv_prev = pins_prev_reg[1];
  wire ov_prev = pins_prev_reg[0];

  wire card_edge = prev_valid_reg && (card_now != card_prev);
  wire fb_fall = prev_valid_reg && fb_prev && !fb_now;
  wire uv_fall = prev_valid_reg && uv_prev && !uv_now;
  wire ov_rise = prev_valid_reg && !ov_prev && ov_now;

  // the sync pipe resets to zero, so edges wait until it has filled;
  // otherwise a pin idling high would log a false change after reset
  wire settle_done = (settle_cnt_reg == 3'(PIN_SETTLE_CYCLES));
  assign settle_cnt_next = settle_done ? settle_cnt_reg : settle_cnt_reg + 3'h1;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pins_prev_reg <= 4'h0;
      settle_cnt_reg <= 3'h0;
      prev_valid_reg <= 1'b0;
    end
    else
    begin
      pins_prev_reg <= pins_sync;
      settle_cnt_reg <= settle_cnt_next;
      prev_valid_reg <= settle_done;
    end
  end

  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  wire [ADDR_W-1:0] addr_lo = reg_addr[ADDR_W-1:0];
  wire sel_fault = (addr_lo == FAULT_LOG_ADDR);
  wire sel_shunt = (addr_lo == SHUNT_RESULT_ADDR);
  wire sel_output = (addr_lo == OUTPUT_RESULT_ADDR);
  wire sel_spare = (addr_lo == SPARE_RESULT_ADDR);
  wire wr_fault = reg_wr && sel_fault;
  wire wr_result_ok = reg_wr && test_mode_bit;

  // ---------------------------------------------
  // fault events
  // ---------------------------------------------
  wire short_seen = !fet_on_cmd && (shunt_voltage_result >= SHORT_THRESHOLD_CODE);
  logic [5:0] event_vec;
  assign event_vec[FLT_SHORT_BIT] = short_seen;
  assign event_vec[FLT_CARD_BIT] = card_edge;
  assign event_vec[FLT_PBAD_BIT] = fb_fall && gate_drive_high;
  assign event_vec[FLT_OC_BIT] = overcurrent_event;
  assign event_vec[FLT_UV_BIT] = uv_fall;
  assign event_vec[FLT_OV_BIT] = ov_rise;

  // ---------------------------------------------
  // fault log, sticky per bit
  // ---------------------------------------------
  logic [DATA_W-1:0] fault_log_next;
  genvar b;
  generate
    for (b = 0; b < 6; b++)
    begin : g_fault
      // set beats the clear so an event in the clearing cycle survives
      assign fault_log_next[b] = event_vec[b] | (wr_fault ? reg_wdata[b] : fault_log[b]);
    end
    for (b = 6; b < DATA_W; b++)
    begin : g_rsvd
      assign fault_log_next[b] = 1'b0;
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (rst)
      fault_log <= FAULT_LOG_RESET;
    else
      fault_log <= fault_log_next;
  end

  // ---------------------------------------------
  // converter results
  // ---------------------------------------------
  // test mode halts sampling, so host writes never race a new sample
  wire load_sample = sample_valid && !test_mode_bit;
  logic [DATA_W-1:0] shunt_next;
  logic [DATA_W-1:0] output_next;
  logic [DATA_W-1:0] spare_next;
  assign shunt_next = (wr_result_ok && sel_shunt) ? reg_wdata :
                      load_sample ? shunt_sample : shunt_voltage_result;
  assign output_next = (wr_result_ok && sel_output) ? reg_wdata :
                       load_sample ? output_sample : output_voltage_result;
  assign spare_next = (wr_result_ok && sel_spare) ? reg_wdata :
                      load_sample ? spare_sample : spare_input_result;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      shunt_voltage_result <= RESULT_RESET;
      output_voltage_result <= RESULT_RESET;
      spare_input_result <= RESULT_RESET;
    end
    else
    begin
      shunt_voltage_result <= shunt_next;
      output_voltage_result <= output_next;
      spare_input_result <= spare_next;
    end
  end

  // ---------------------------------------------
  // read path, registered
  // ---------------------------------------------
  logic [DATA_W-1:0] rdata_next;
  assign rdata_next = sel_fault ? (fault_log & FAULT_LOG_MASK) :
                      sel_shunt ? shunt_voltage_result :
                      sel_output ? output_voltage_result :
                      sel_spare ? spare_input_result : 8'h00;

  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= rdata_next;
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  sequence s_clear_fault;
    wr_fault && reg_wdata[FLT_OC_BIT] == 1'b0 && !overcurrent_event;
  endsequence

  a_short_sets: assert property (@(posedge mclk) disable iff (rst)
    (!fet_on_cmd && shunt_voltage_result >= SHORT_THRESHOLD_CODE) |=> fault_log[5])
    else $error("short fault not latched");
  a_card_change: assert property (@(posedge mclk) disable iff (rst)
    (prev_valid_reg && $changed(card_now)) |-> ##1 fault_log[4])
    else $error("card change not latched");
  a_pbad_gate: assert property (@(posedge mclk) disable iff (rst)
    (!fault_log[3] && !(wr_fault && reg_wdata[3]) && !(fb_prev && !fb_now && gate_drive_high))
    |=> !fault_log[3])
    else $error("power bad set without cause");
  a_oc_clear: assert property (@(posedge mclk) disable iff (rst)
    s_clear_fault |=> !fault_log[2])
    else $error("overcurrent bit not cleared");
  a_oc_sets: assert property (@(posedge mclk) disable iff (rst)
    overcurrent_event |=> fault_log[2] [*1] ##0 (fault_log[2] || $past(wr_fault)))
    else $error("overcurrent not latched");
  a_uv_fall: assert property (@(posedge mclk) disable iff (rst)
    (prev_valid_reg && $fell(uv_now)) |-> ##1 fault_log[1])
    else $error("undervoltage not latched");
  a_ov_rise: assert property (@(posedge mclk) disable iff (rst)
    (prev_valid_reg && $rose(ov_now)) |-> ##1 fault_log[0])
    else $error("overvoltage not latched");
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (rst)
    fault_log[7:6] == 2'b00)
    else $error("reserved fault bits set");
  a_result_lock: assert property (@(posedge mclk) disable iff (rst)
    (!test_mode_bit && !sample_valid) |=> $stable(shunt_voltage_result) && $stable(spare_input_result)
      && $stable(output_voltage_result))
    else $error("result changed without sample");
  a_read_shunt: assert property (@(posedge mclk) disable iff (rst)
    (sel_shunt && !reg_wr && !sample_valid) |=> reg_rdata == $past(shunt_voltage_result))
    else $error("shunt read mismatch");

  // ---------------------------------------------
  // assertions on the host, sample and fault event paths
  // ---------------------------------------------
  sequence s_sample_arrives;
    sample_valid && !test_mode_bit;
  endsequence

  sequence s_host_result_write;
    reg_wr && test_mode_bit;
  endsequence

  sequence s_fault_write_live;
    wr_fault && (event_vec != 6'h00);
  endsequence

  a_sample_load: assert property (@(posedge mclk) disable iff (rst)
    s_sample_arrives |=> shunt_voltage_result == $past(shunt_sample)
      && output_voltage_result == $past(output_sample) && spare_input_result == $past(spare_sample))
    else $error("sample not loaded whole");
  a_test_write: assert property (@(posedge mclk) disable iff (rst)
    s_host_result_write ##0 sel_shunt
    |=> shunt_voltage_result == $past(reg_wdata))
    else $error("shunt test write lost");
  a_output_write: assert property (@(posedge mclk) disable iff (rst)
    s_host_result_write ##0 sel_output
    |=> output_voltage_result == $past(reg_wdata))
    else $error("output test write lost");
  a_spare_write: assert property (@(posedge mclk) disable iff (rst)
    s_host_result_write ##0 sel_spare
    |=> spare_input_result == $past(reg_wdata))
    else $error("spare test write lost");
  a_locked_write: assert property (@(posedge mclk) disable iff (rst)
    (reg_wr && !test_mode_bit && !sample_valid)
    |=> $stable(shunt_voltage_result) && $stable(output_voltage_result) && $stable(spare_input_result))
    else $error("result written outside test mode");
  a_fault_read: assert property (@(posedge mclk) disable iff (rst)
    sel_fault
    |=> reg_rdata == ($past(fault_log) & FAULT_LOG_MASK))
    else $error("fault log read mismatch");
  a_unmapped_read: assert property (@(posedge mclk) disable iff (rst)
    !(sel_fault || sel_shunt || sel_output || sel_spare)
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_fault_sticky: assert property (@(posedge mclk) disable iff (rst)
    !wr_fault
    |=> (fault_log & $past(fault_log)) == $past(fault_log))
    else $error("fault bit dropped without write");
  a_event_wins: assert property (@(posedge mclk) disable iff (rst)
    s_fault_write_live
    |=> (fault_log[5:0] & $past(event_vec)) == $past(event_vec))
    else $error("clear beat a live fault");
  a_short_quiet: assert property (@(posedge mclk) disable iff (rst)
    (fet_on_cmd && !fault_log[5] && !(wr_fault && reg_wdata[5]))
    |=> !fault_log[5])
    else $error("short logged while transistor on");
  a_oc_quiet: assert property (@(posedge mclk) disable iff (rst)
    (!overcurrent_event && !fault_log[2] && !(wr_fault && reg_wdata[2]))
    |=> !fault_log[2])
    else $error("overcurrent logged without event");
  a_pbad_sets: assert property (@(posedge mclk) disable iff (rst)
    (fb_fall && gate_drive_high)
    |=> fault_log[3])
    else $error("power bad not latched");
  a_uv_quiet: assert property (@(posedge mclk) disable iff (rst)
    (!uv_fall && !fault_log[1] && !(wr_fault && reg_wdata[1]))
    |=> !fault_log[1])
    else $error("undervoltage logged without fall");
  a_ov_quiet: assert property (@(posedge mclk) disable iff (rst)
    (!ov_rise && !fault_log[0] && !(wr_fault && reg_wdata[0]))
    |=> !fault_log[0])
    else $error("overvoltage logged without rise");
endmodule : flr_regs

// >>> testbench/flr_host_model.sv
// host model issuing register reads and writes
`timescale 1ns/10ps
module flr_host_model
  import flr_pkg::*;
(
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata
);
  // ----
  // bus cycles
  // ----
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // a zero written to a fault bit is the only way it clears
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    @(posedge mclk);
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : flr_host_model

// >>> testbench/flr_regs_tb.sv
// self-checking bench for the fault log and result register bank
`timescale 1ns/10ps
module flr_regs_tb
  import flr_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fault_log, sh_r, out_r, sp_r, sh_s, out_s, sp_s, d;
  logic test_mode, fet_on, oc, gate_hi, card, fb, uv, ov, sv;
  logic [23:0] smp;
  logic [4:0] hi;
  logic [7:0] fa = {5'h00, FAULT_LOG_ADDR};
  int seed = 49321;
  int bad_count = 0;
  int checks_done = 0;
  always #50 mclk = ~mclk;
  flr_regs i_flr_regs (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .test_mode_bit(test_mode), .fet_on_cmd(fet_on), .overcurrent_event(oc),
    .gate_drive_high(gate_hi), .card_presence_pin(card), .power_good_feedback(fb),
    .low_limit_comparator_input(uv), .high_limit_comparator_input(ov), .sample_valid(sv),
    .shunt_sample(sh_s), .output_sample(out_s), .spare_sample(sp_s), .fault_log(fault_log),
    .shunt_voltage_result(sh_r), .output_voltage_result(out_r), .spare_input_result(sp_r));
  flr_host_model i_flr_host_model (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata));
  // ----
  // checking helpers
  // ----
  function automatic logic [7:0] fbit(input int b);
    return 8'h01 << b;
  endfunction : fbit
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // pins pass a synchroniser, so allow a bounded settling time
  task automatic pin_chk(input int b, input bit on);
    for (int n = 0; n < 20 && (!on || fault_log[b] !== 1'b1); n++)
    begin
      @(posedge mclk);
      #1;
    end
    chk(fault_log, on ? fbit(b) : 8'h00);
    if (on && fault_log[b] !== 1'b1)
      final_report();
    i_flr_host_model.wr(fa, 8'h00);
  endtask : pin_chk
  // ----
  // main sequence
  // ----
  initial
  begin
    {test_mode, oc, gate_hi, card, ov, sv} = 6'h00;
    {fet_on, fb, uv} = 3'h7;
    {sh_s, out_s, sp_s} = 24'h000000;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    for (int a = 0; a < 8; a++)
    begin
      i_flr_host_model.rd(a[7:0], d);
      chk(d, 8'h00);
    end
    repeat (8)
    begin
      smp = 24'($random(seed));
      {sh_s, out_s, sp_s} = smp;
      sv = 1'b1;
      @(posedge mclk);
      #1;
      sv = 1'b0;
      {sh_s, out_s, sp_s} = ~smp;
      hi = 5'($random(seed));
      i_flr_host_model.rd({hi, SHUNT_RESULT_ADDR}, d);
      chk(d, smp[23:16]);
      i_flr_host_model.rd({hi, OUTPUT_RESULT_ADDR}, d);
      chk(d, smp[15:8]);
      i_flr_host_model.rd({hi, SPARE_RESULT_ADDR}, d);
      chk(d, smp[7:0]);
    end
    i_flr_host_model.wr({5'h1f, SHUNT_RESULT_ADDR}, 8'h5a);
    chk(sh_r, smp[23:16]);
    test_mode = 1'b1;
    sv = 1'b1;
    @(posedge mclk);
    #1;
    sv = 1'b0;
    chk(out_r, smp[15:8]);
    chk(sp_r, smp[7:0]);
    for (int k = 4; k < 7; k++)
    begin
      i_flr_host_model.wr({hi, 3'(k)}, 8'(k * 8'h21));
      i_flr_host_model.rd({~hi, 3'(k)}, d);
      chk(d, 8'(k * 8'h21));
    end
    i_flr_host_model.wr({5'h00, SHUNT_RESULT_ADDR}, SHORT_THRESHOLD_CODE - 8'h01);
    fet_on = 1'b0;
    pin_chk(FLT_SHORT_BIT, 1'b0);
    i_flr_host_model.wr({5'h00, SHUNT_RESULT_ADDR}, SHORT_THRESHOLD_CODE);
    pin_chk(FLT_SHORT_BIT, 1'b1);
    fet_on = 1'b1;
    chk(fault_log, fbit(FLT_SHORT_BIT));
    i_flr_host_model.wr(fa, 8'h00);
    pin_chk(FLT_SHORT_BIT, 1'b0);
    oc = 1'b1;
    i_flr_host_model.wr(fa, 8'h00);
    chk(fault_log, fbit(FLT_OC_BIT));
    oc = 1'b0;
    i_flr_host_model.wr(fa, 8'hff);
    i_flr_host_model.rd(fa, d);
    chk(d, FAULT_LOG_MASK);
    i_flr_host_model.wr(fa, 8'h00);
    pin_chk(FLT_OC_BIT, 1'b0);
    card = 1'b1;
    pin_chk(FLT_CARD_BIT, 1'b1);
    card = 1'b0;
    pin_chk(FLT_CARD_BIT, 1'b1);
    uv = 1'b0;
    pin_chk(FLT_UV_BIT, 1'b1);
    ov = 1'b1;
    pin_chk(FLT_OV_BIT, 1'b1);
    fb = 1'b0;
    pin_chk(FLT_PBAD_BIT, 1'b0);
    fb = 1'b1;
    gate_hi = 1'b1;
    pin_chk(FLT_PBAD_BIT, 1'b0);
    fb = 1'b0;
    pin_chk(FLT_PBAD_BIT, 1'b1);
    final_report();
  end
endmodule : flr_regs_tb
